//--- logic/fsp_fifo.sv
// Purpose: synchronous fifo with valid and ready on both sides
// Assumes: depth a power of two
// Notes: level output lets the owner run watermarks
`timescale 1ns/1ps
module fsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fsp_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;
    always_comb
    begin
        push = ce_in && in_valid_in && in_ready_out;
        pop = ce_in && out_valid_out && out_ready_in;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end
    always_ff @(posedge core_clk_in)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
    assign level_out = wr_q - rd_q;
    assign in_ready_out = level_out != (AW+1)'(DEPTH);
    assign out_valid_out = level_out != '0;
    assign out_data_out = mem_q[rd_q[AW-1:0]];
endmodule

//--- logic/fsp_pkg.sv
// Purpose: constants and carrier types of the fixed rate serial port
// Assumes: 25 MHz core clock, one clock domain
package fsp_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int BAUD_RATE = 9600;
    localparam int BIT_CYC = CLK_HZ / BAUD_RATE;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam int DATA_BITS = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int HI_MARK = 24;
    localparam int LO_MARK = 8;
    localparam logic [7:0] CHAR_RESUME = 8'h11;
    localparam logic [7:0] CHAR_PAUSE = 8'h13;
    localparam logic LINE_IDLE = 1'b1;

    typedef struct packed {
        logic carrier_det;
        logic set_ready;
        logic clear_to_send;
    } fsp_modem_t;
endpackage

//--- logic/fsp_port.sv
// Purpose: fixed rate serial port with in-band software flow control
// Assumes: core clock 25 MHz, line inputs synchronous to it
// Notes: received data passes a fifo; its fill level drives pause/resume
`timescale 1ns/1ps
module fsp_port
    import fsp_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic rx_line_in,
    output logic tx_line_out,
    input wire logic term_ready_in,
    output fsp_pkg::fsp_modem_t modem_out,
    output logic term_ready_out,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_data_in,
    output logic tx_ready_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic [7:0] rx_data_out,
    output logic tx_paused_out
);
    import fsp_pkg::*;
    initial
    begin
        if (BIT_CYCLES < 4 || BIT_CYCLES > 65535)
            $error("fsp_port bit period out of range");
    end

    function automatic logic is_flow(input logic [7:0] c);
        is_flow = (c == CHAR_RESUME) || (c == CHAR_PAUSE);
    endfunction

    // fifo level has crossed the watermark that asks for the other flow char
    function automatic logic flow_due(input logic want, input logic [5:0] lvl);
        flow_due = want ? (lvl <= 6'(LO_MARK)) : (lvl >= 6'(HI_MARK));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b10,
        ST_STOP = 2'b11
    } fsp_state_t;

    localparam logic [15:0] FULL_BIT = 16'(BIT_CYCLES);
    localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2);

    // receive side
    fsp_state_t rx_st_q, rx_st_d;
    logic [15:0] rx_cnt_q, rx_cnt_d;
    logic [2:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic rx_push;
    logic rx_seen_pause, rx_seen_resume;
    logic f_in_ready;
    logic [$clog2(FIFO_DEPTH):0] f_level;
    logic f_valid;
    logic [7:0] f_data;

    always_comb
    begin
        rx_st_d = rx_st_q;
        rx_cnt_d = rx_cnt_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        rx_push = 1'b0;
        rx_seen_pause = 1'b0;
        rx_seen_resume = 1'b0;
        case (rx_st_q)
            ST_IDLE:
            begin
                if (rx_line_in != LINE_IDLE)
                begin
                    rx_st_d = ST_START;
                    rx_cnt_d = HALF_BIT;
                end
            end
            ST_START:
            begin
                if (rx_cnt_q == 16'h0001)
                begin
                    rx_cnt_d = FULL_BIT;
                    rx_bit_d = 3'h0;
                    // a glitch shorter than half a bit is dropped
                    rx_st_d = (rx_line_in == LINE_IDLE) ? ST_IDLE : ST_DATA;
                end
                else
                    rx_cnt_d = rx_cnt_q - 16'h0001;
            end
            ST_DATA:
            begin
                if (rx_cnt_q == 16'h0001)
                begin
                    rx_cnt_d = FULL_BIT;
                    rx_sh_d = {rx_line_in, rx_sh_q[7:1]};
                    rx_bit_d = rx_bit_q + 3'h1;
                    if (rx_bit_q == 3'(DATA_BITS - 1))
                        rx_st_d = ST_STOP;
                end
                else
                    rx_cnt_d = rx_cnt_q - 16'h0001;
            end
            ST_STOP:
            begin
                if (rx_cnt_q == 16'h0001)
                begin
                    rx_st_d = ST_IDLE;
                    // framing error: character dropped, no parity checked
                    if (rx_line_in == LINE_IDLE)
                    begin
                        rx_seen_resume = rx_sh_q == CHAR_RESUME;
                        rx_seen_pause = rx_sh_q == CHAR_PAUSE;
                        rx_push = !is_flow(rx_sh_q);
                    end
                end
                else
                    rx_cnt_d = rx_cnt_q - 16'h0001;
            end
            default: rx_st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rx_st_q <= ST_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
        end
        else if (ce_in)
        begin
            rx_st_q <= rx_st_d;
            rx_cnt_q <= rx_cnt_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
        end
    end

    // fifo overflow loses the character; pause is sent well before full
    fsp_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .in_valid_in(rx_push),
        .in_ready_out(f_in_ready),
        .in_data_in(rx_sh_q),
        .out_valid_out(f_valid),
        .out_ready_in(rx_ready_in && !rx_valid_out),
        .out_data_out(f_data),
        .level_out(f_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // flow state and output stage
    logic paused_q, paused_d;
    logic want_pause_q, want_pause_d;
    logic send_flow_q, send_flow_d;
    logic rx_valid_q, rx_valid_d;
    logic [7:0] rx_data_q, rx_data_d;
    logic dtr_q;
    logic flow_taken;

    always_comb
    begin
        paused_d = paused_q;
        if (rx_seen_pause)
            paused_d = 1'b1;
        else if (rx_seen_resume)
            paused_d = 1'b0;
        want_pause_d = want_pause_q;
        send_flow_d = send_flow_q && !flow_taken;
        if (flow_due(want_pause_q, f_level))
        begin
            want_pause_d = !want_pause_q;
            send_flow_d = 1'b1;
        end
        rx_valid_d = rx_valid_q;
        rx_data_d = rx_data_q;
        if (rx_valid_q && rx_ready_in)
            rx_valid_d = 1'b0;
        if (f_valid && rx_ready_in && !rx_valid_q)
        begin
            rx_valid_d = 1'b1;
            rx_data_d = f_data;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            paused_q <= 1'b0;
            want_pause_q <= 1'b0;
            send_flow_q <= 1'b0;
            rx_valid_q <= 1'b0;
            rx_data_q <= 8'h00;
            dtr_q <= 1'b0;
        end
        else if (ce_in)
        begin
            paused_q <= paused_d;
            want_pause_q <= want_pause_d;
            send_flow_q <= send_flow_d;
            rx_valid_q <= rx_valid_d;
            rx_data_q <= rx_data_d;
            dtr_q <= term_ready_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit side: 10 bit frame, lsb first; flow chars jump the queue
    logic [9:0] tx_sh_q, tx_sh_d;
    logic [3:0] tx_left_q, tx_left_d;
    logic [15:0] tx_cnt_q, tx_cnt_d;
    logic tx_ready_q, tx_ready_d;
    logic tx_line_q, tx_line_d;

    always_comb
    begin
        tx_sh_d = tx_sh_q;
        tx_left_d = tx_left_q;
        tx_cnt_d = tx_cnt_q;
        tx_line_d = tx_line_q;
        flow_taken = 1'b0;
        tx_ready_d = 1'b0;
        if (tx_left_q != 4'h0)
        begin
            if (tx_cnt_q == 16'h0001)
            begin
                tx_cnt_d = FULL_BIT;
                tx_sh_d = {LINE_IDLE, tx_sh_q[9:1]};
                tx_left_d = tx_left_q - 4'h1;
                tx_line_d = tx_left_q == 4'h1 ? LINE_IDLE : tx_sh_q[1];
            end
            else
                tx_cnt_d = tx_cnt_q - 16'h0001;
        end
        else if (send_flow_q)
        begin
            flow_taken = 1'b1;
            tx_sh_d = {1'b1, want_pause_q ? CHAR_PAUSE : CHAR_RESUME, 1'b0};
            tx_left_d = 4'ha;
            tx_cnt_d = FULL_BIT;
            tx_line_d = 1'b0;
        end
        else if (tx_valid_in && tx_ready_q && !paused_q)
        begin
            tx_sh_d = {1'b1, tx_data_in, 1'b0};
            tx_left_d = 4'ha;
            tx_cnt_d = FULL_BIT;
            tx_line_d = 1'b0;
        end
        // ready looks one cycle ahead so it never stands beside a pause or a flow char
        else
            tx_ready_d = !paused_q && !rx_seen_pause && !send_flow_q
                && !flow_due(want_pause_q, f_level);
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            tx_sh_q <= 10'h3ff;
            tx_left_q <= 4'h0;
            tx_cnt_q <= 16'h0000;
            tx_ready_q <= 1'b0;
            tx_line_q <= 1'b1;
        end
        else if (ce_in)
        begin
            tx_sh_q <= tx_sh_d;
            tx_left_q <= tx_left_d;
            tx_cnt_q <= tx_cnt_d;
            tx_ready_q <= tx_ready_d;
            tx_line_q <= tx_line_d;
        end
    end

    // modem lines are constants from flops; cts always driven asserted
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            modem_out <= '{carrier_det: 1'b1, set_ready: 1'b1, clear_to_send: 1'b1};
        else
            modem_out <= '{carrier_det: 1'b1, set_ready: 1'b1, clear_to_send: 1'b1};
    end

    assign tx_line_out = tx_line_q;
    assign tx_ready_out = tx_ready_q;
    assign rx_valid_out = rx_valid_q;
    assign rx_data_out = rx_data_q;
    assign term_ready_out = dtr_q;
    assign tx_paused_out = paused_q;

    ////////////////////////////////////////////////////////////////////////
    AST_MODEM_HELD: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        modem_out == 3'b111) else $error("modem lines not asserted");
    AST_CTS_DRIVEN: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        modem_out.clear_to_send) else $error("cts dropped");
    AST_DTR_SAMPLED: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        ce_in |=> term_ready_out == $past(term_ready_in)) else $error("dtr lost");
    AST_NO_FLOW_OUT: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        rx_valid_out |-> !is_flow(rx_data_out)) else $error("flow char leaked");
    AST_PAUSE_SEEN: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        ce_in && rx_seen_pause |=> tx_paused_out) else $error("pause ignored");
    AST_PAUSE_BLOCKS: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        tx_paused_out |-> !tx_ready_out) else $error("ready while paused");
    AST_START_BIT: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        ce_in && tx_left_q == 4'h0 && tx_left_d == 4'ha |=> !tx_line_out)
        else $error("start bit missing");
    AST_STOP_LEVEL: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        tx_left_q == 4'h0 |-> tx_line_out) else $error("line not idle high");
    AST_BIT_TIME: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        tx_cnt_q <= FULL_BIT) else $error("bit counter over period");
    COV_TX: cover property (@(posedge core_clk_in) tx_valid_in && tx_ready_out);
    COV_RX: cover property (@(posedge core_clk_in) rx_valid_out && rx_ready_in);
    COV_PAUSE: cover property (@(posedge core_clk_in) flow_taken && want_pause_q);
endmodule

//--- sim/fsp_host.sv
// Purpose: host serial port model facing the port's line pins
// Assumes: shares the bench clock, BIT_CYCLES clocks per bit
// Notes: obeys a received pause unless a send is forced through
`timescale 1ns/1ps
module fsp_host #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic clk_in,
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] got_q[$];
    logic paused = 1'b0;
    logic [7:0] rb;
    int bad_stops = 0;

    initial line_out = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // receive: sample at falling clock edges so the port's register has settled
    always
    begin
        @(negedge line_in);
        repeat (BIT_CYCLES / 2) @(negedge clk_in);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYCLES) @(negedge clk_in);
            rb[i] = line_in;
        end
        repeat (BIT_CYCLES) @(negedge clk_in);
        if (line_in !== 1'b1)
            bad_stops++;
        if (rb == 8'h13)
            paused = 1'b1;
        if (rb == 8'h11)
            paused = 1'b0;
        got_q.push_back(rb);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // send: lsb first; a forced send ignores pause to overrun the port on purpose
    task automatic send(input logic [7:0] c, input logic stop, input logic force_it);
        logic [9:0] f;
        f = {stop, c, 1'b0};
        while (paused && !force_it)
            @(negedge clk_in);
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk_in);
            line_out = f[i];
            repeat (BIT_CYCLES - 1) @(negedge clk_in);
        end
        @(negedge clk_in);
        line_out = 1'b1;
        repeat (2 * BIT_CYCLES) @(negedge clk_in);
    endtask
endmodule

//--- sim/fsp_port_bench.sv
// Purpose: self-checking bench of the serial port against a host model
// Assumes: short bit time of 8 clocks, inputs change at falling edges
// Notes: reset and terminal ready checks, table rows, then pause, framing, fifo and reset cases
`timescale 1ns/1ps
`define CHK(nm, e, g) check_count++; \
    if ((g) !== (e)) begin $display("ERROR %s expected %h seen %h", nm, e, g); \
    miscompares++; end
module fsp_port_bench;
    import fsp_pkg::*;
    localparam int BITC = 8;
    typedef struct packed {
        logic to_host;
        logic [7:0] val;
    } fsp_row_t;
    logic clk, arst_n, ce, rx_line, tx_line, term_ready, term_ready_seen;
    logic tx_valid, tx_ready, rx_valid, rx_ready, tx_paused;
    logic [7:0] tx_data, rx_data, got;
    fsp_modem_t modem;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    fsp_row_t rows[8] = '{'{1'b1, 8'h00}, '{1'b1, 8'hff}, '{1'b1, 8'ha5}, '{1'b0, 8'h5a},
        '{1'b0, 8'h00}, '{1'b0, 8'hff}, '{1'b0, 8'h3c}, '{1'b1, 8'hc3}};

    fsp_port #(.BIT_CYCLES(BITC)) fsp_port_i (.core_clk_in(clk), .arst_n_in(arst_n),
        .ce_in(ce), .rx_line_in(rx_line), .tx_line_out(tx_line), .term_ready_in(term_ready),
        .modem_out(modem), .term_ready_out(term_ready_seen), .tx_valid_in(tx_valid),
        .tx_data_in(tx_data), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
        .rx_ready_in(rx_ready), .rx_data_out(rx_data), .tx_paused_out(tx_paused));
    fsp_host #(.BIT_CYCLES(BITC)) fsp_host_i (.clk_in(clk), .line_in(tx_line),
        .line_out(rx_line));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ceiling well above the roughly 5000 clocks the cases need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            results();
        end
    end

    // trailing wait keeps two calls from driving one signal in one time step
    task automatic put_tx(input logic [7:0] c);
        int n;
        n = 0;
        tx_valid = 1'b1;
        tx_data = c;
        while (tx_ready !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        tx_valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic get_rx(output logic [7:0] c);
        int n;
        n = 0;
        rx_ready = 1'b1;
        while (rx_valid !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        c = rx_data;
        @(negedge clk);
        rx_ready = 1'b0;
        @(negedge clk);
    endtask

    task automatic get_host(output logic [7:0] c);
        int n;
        n = 0;
        while (fsp_host_i.got_q.size() == 0 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        c = (fsp_host_i.got_q.size() > 0) ? fsp_host_i.got_q.pop_front() : 8'hxx;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        arst_n = 1'b0;
        ce = 1'b1;
        term_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_ready = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("modem in reset", 3'b111, modem)
        `CHK("ready in reset", 1'b0, tx_ready)
        `CHK("line idle", 1'b1, tx_line)
        arst_n = 1'b1;
        @(negedge clk);
        `CHK("ready first edge", 1'b1, tx_ready)
        term_ready = 1'b1;
        @(negedge clk);
        `CHK("ready second edge", 1'b1, tx_ready)
        `CHK("terminal ready high", 1'b1, term_ready_seen)
        term_ready = 1'b0;
        @(negedge clk);
        `CHK("terminal ready low", 1'b0, term_ready_seen)
        foreach (rows[i])
        begin
            if (rows[i].to_host)
            begin
                put_tx(rows[i].val);
                get_host(got);
            end
            else
            begin
                fsp_host_i.send(rows[i].val, 1'b1, 1'b0);
                get_rx(got);
            end
            `CHK("row byte", rows[i].val, got)
        end
        fsp_host_i.send(8'h13, 1'b1, 1'b0);
        fsp_host_i.send(8'h42, 1'b1, 1'b0);
        get_rx(got);
        `CHK("pause stripped", 8'h42, got)
        `CHK("paused flag", 1'b1, tx_paused)
        tx_valid = 1'b1;
        tx_data = 8'h77;
        repeat (3 * BITC) @(negedge clk);
        `CHK("refused while paused", 1'b0, tx_ready)
        tx_valid = 1'b0;
        fsp_host_i.send(8'h11, 1'b1, 1'b0);
        `CHK("resumed", 1'b0, tx_paused)
        put_tx(8'h77);
        get_host(got);
        `CHK("sent after resume", 8'h77, got)
        fsp_host_i.send(8'h55, 1'b0, 1'b0);
        fsp_host_i.send(8'h66, 1'b1, 1'b0);
        get_rx(got);
        `CHK("bad stop dropped", 8'h66, got)
        // overrun: 33 chars into a 32 deep fifo, the last one is lost
        for (int i = 0; i < 33; i++)
            fsp_host_i.send(8'(8'h20 + i), 1'b1, 1'b1);
        get_host(got);
        `CHK("pause sent", 8'h13, got)
        for (int i = 0; i < 32; i++)
        begin
            get_rx(got);
            `CHK("fifo order", 8'(8'h20 + i), got)
            if (i == 23)
            begin
                get_host(got);
                `CHK("resume sent", 8'h11, got)
            end
        end
        // consumer stays ready so a surviving overrun char would show up here
        rx_ready = 1'b1;
        got = 8'h00;
        repeat (4 * BITC)
        begin
            @(negedge clk);
            got = got | {7'h00, rx_valid};
        end
        rx_ready = 1'b0;
        `CHK("overrun char lost", 8'h00, got)
        `CHK("pause sent once", 0, fsp_host_i.got_q.size())
        `CHK("stop bits", 0, fsp_host_i.bad_stops)
        tx_valid = 1'b1;
        tx_data = 8'h00;
        repeat (2 * BITC) @(negedge clk);
        arst_n = 1'b0;
        tx_valid = 1'b0;
        @(negedge clk);
        `CHK("line after reset", 1'b1, tx_line)
        `CHK("modem after reset", 3'b111, modem)
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("ready after reset", 1'b1, tx_ready)
        results();
    end
endmodule
